// *** verilog/gang_handshake_pkg.sv ***
// Shared constants and types for the four-unit handler handshake.
// Assumes a single 200 MHz clock; every time below is in its own unit.
`default_nettype none
package gang_handshake_pkg;
   localparam int unsigned UNITS           = 4;
   localparam int unsigned CLOCK_PERIOD_NS = 5;
   localparam int unsigned MS_IN_NS        = 1_000_000;
   // Limits of the start pulse width, in milliseconds
   localparam int unsigned GO_MIN_MS       = 50;
   localparam int unsigned GO_MAX_MS       = 80;
   localparam int unsigned CYCLES_PER_MS   = MS_IN_NS / CLOCK_PERIOD_NS;
   localparam int unsigned WIDTH_CNT_W     = 7;
   localparam logic [WIDTH_CNT_W-1:0] WIDTH_CNT_MAX = 7'h7F;
   // Tick phase is unknown, so a measured width may read one below the true one
   localparam logic [WIDTH_CNT_W-1:0] GO_PULSE_WIDTH_LO = 7'(GO_MIN_MS - 1);
   localparam logic [WIDTH_CNT_W-1:0] GO_PULSE_WIDTH_HI = 7'(GO_MAX_MS);
   localparam logic [3:0] LINES_IDLE = 4'hF;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WORK = 3'b010,
      ST_DONE = 3'b100
   } unit_state_t;

   // Lines toward the handler, one bit per unit, all active low
   typedef struct packed {
      logic [UNITS-1:0] unit_working_n;
      logic [UNITS-1:0] unit_result_good_n;
      logic [UNITS-1:0] unit_result_bad_n;
   } unit_lines_t;

   // Report from the programming engines, one bit per unit
   typedef struct packed {
      logic [UNITS-1:0] done;
      logic [UNITS-1:0] pass;
      logic [UNITS-1:0] pause;
   } engine_status_t;
endpackage
`default_nettype wire

// *** verilog/ms_tick_divider.sv ***
// One-cycle enable pulse once per millisecond.
// Assumes the single system clock and its asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module ms_tick_divider #(
   parameter int unsigned CYCLES = 200_000
) (
   input  wire logic i_clock,
   input  wire logic i_reset_n,
   output var  logic o_tick
);
   typedef struct packed {
      logic [31:0] count;
      logic        tick;
   } div_state_t;

   div_state_t st_reg;
   div_state_t st_next;

   always_comb begin
      st_next      = st_reg;
      st_next.tick = 1'b0;
      if (st_reg.count == 32'(CYCLES - 1)) begin
         st_next.count = 32'h0000_0000;
         st_next.tick  = 1'b1;
      end else begin
         st_next.count = st_reg.count + 32'h0000_0001;
      end
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_tick = st_reg.tick;

   a_tick_spacing : assert property (@(posedge i_clock) disable iff (!i_reset_n)
      o_tick |=> !o_tick) else $error("tick lasted more than one cycle");
endmodule // ms_tick_divider
`default_nettype wire

// *** verilog/gang_programmer_handshake.sv ***
// Control-bus handshake of four programming units toward an IC handler.
// Assumes start request and mode pins arrive asynchronously; engine status is on i_clock.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - After reset every busy, pass and fail line sits high and every engine start output is low.
// - Accepted start drives busy low; busy may rise briefly during work.
// - On completion busy rises and exactly one of pass or fail goes low.
// - In single-start mode each unit starts only from its own request line.
module gang_programmer_handshake
   import gang_handshake_pkg::*;
#(
   parameter int unsigned CYCLES_PER_MS_P = gang_handshake_pkg::CYCLES_PER_MS
) (
   input  wire logic                              i_clock,
   input  wire logic                              i_reset_n,
   input  wire logic [gang_handshake_pkg::UNITS-1:0] i_unit_go_request_n,
   input  wire logic                              i_all_start_mode,
   input  wire logic                              i_all_start_n,
   input  wire gang_handshake_pkg::engine_status_t i_engine,
   output var  gang_handshake_pkg::unit_lines_t   o_unit_lines,
   output var  logic [gang_handshake_pkg::UNITS-1:0] o_engine_start
);
   import gang_handshake_pkg::*;

   typedef struct packed {
      logic [UNITS-1:0]                  go_meta;
      logic [UNITS-1:0]                  go_sync;
      logic [UNITS-1:0]                  go_prev;
      logic                              mode_meta;
      logic                              mode_sync;
      logic                              all_meta;
      logic                              all_sync;
      logic                              all_prev;
      unit_state_t [UNITS-1:0]           unit;
      logic [UNITS-1:0][WIDTH_CNT_W-1:0] low_cnt;
      unit_lines_t                       lines;
      logic [UNITS-1:0]                  engine_start;
   } hs_state_t;

   hs_state_t        st_reg;
   hs_state_t        st_next;
   logic             ms_tick;
   logic [UNITS-1:0] start_ok;
   logic [UNITS-1:0] width_ok;

   function automatic logic go_width_ok(input logic [WIDTH_CNT_W-1:0] cnt);
      go_width_ok = (cnt >= GO_PULSE_WIDTH_LO) && (cnt <= GO_PULSE_WIDTH_HI);
   endfunction

   ms_tick_divider #(
      .CYCLES (CYCLES_PER_MS_P)
   ) u_ms_tick (
      .i_clock   (i_clock),
      .i_reset_n (i_reset_n),
      .o_tick    (ms_tick)
   );

   always_comb begin
      st_next              = st_reg;
      st_next.go_meta      = i_unit_go_request_n;
      st_next.go_sync      = st_reg.go_meta;
      st_next.go_prev      = st_reg.go_sync;
      st_next.mode_meta    = i_all_start_mode;
      st_next.mode_sync    = st_reg.mode_meta;
      st_next.all_meta     = i_all_start_n;
      st_next.all_sync     = st_reg.all_meta;
      st_next.all_prev     = st_reg.all_sync;
      st_next.engine_start = '0;
      start_ok             = '0;
      width_ok             = '0;
      for (int u = 0; u < UNITS; u++) begin
         // Width of the low phase in whole milliseconds, saturating
         if (st_reg.go_sync[u]) begin
            st_next.low_cnt[u] = '0;
         end else if (ms_tick && st_reg.low_cnt[u] != WIDTH_CNT_MAX) begin
            st_next.low_cnt[u] = st_reg.low_cnt[u] + 7'h01;
         end
         width_ok[u] = go_width_ok(st_reg.low_cnt[u]);
         // In single-start mode a request counts at its rising edge, only if the width was legal; the shared start counts at its falling edge
         if (st_reg.mode_sync) begin
            start_ok[u] = !st_reg.all_sync && st_reg.all_prev;
         end else begin
            start_ok[u] = st_reg.go_sync[u] && !st_reg.go_prev[u]
                          && width_ok[u];
         end
         case (st_reg.unit[u])
            ST_IDLE, ST_DONE: begin
               if (start_ok[u]) begin
                  st_next.unit[u]                     = ST_WORK;
                  st_next.engine_start[u]             = 1'b1;
                  st_next.lines.unit_working_n[u]     = 1'b0;
                  st_next.lines.unit_result_good_n[u] = 1'b1;
                  st_next.lines.unit_result_bad_n[u]  = 1'b1;
               end
            end
            ST_WORK: begin
               if (i_engine.done[u]) begin
                  st_next.unit[u]                     = ST_DONE;
                  st_next.lines.unit_working_n[u]     = 1'b1;
                  st_next.lines.unit_result_good_n[u] = !i_engine.pass[u];
                  st_next.lines.unit_result_bad_n[u]  = i_engine.pass[u];
               end else begin
                  // Busy may go high while the engine pauses; results stay high
                  st_next.lines.unit_working_n[u]     = i_engine.pause[u];
               end
            end
            default: begin
               st_next.unit[u]                     = ST_IDLE;
               st_next.lines.unit_working_n[u]     = 1'b1;
               st_next.lines.unit_result_good_n[u] = 1'b1;
               st_next.lines.unit_result_bad_n[u]  = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_reg.go_meta      <= LINES_IDLE;
         st_reg.go_sync      <= LINES_IDLE;
         st_reg.go_prev      <= LINES_IDLE;
         st_reg.mode_meta    <= 1'b0;
         st_reg.mode_sync    <= 1'b0;
         st_reg.all_meta     <= 1'b1;
         st_reg.all_sync     <= 1'b1;
         st_reg.all_prev     <= 1'b1;
         st_reg.unit         <= {UNITS{ST_IDLE}};
         st_reg.low_cnt      <= '0;
         st_reg.lines        <= {LINES_IDLE, LINES_IDLE, LINES_IDLE};
         st_reg.engine_start <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_unit_lines   = st_reg.lines;
   assign o_engine_start = st_reg.engine_start;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);

   for (genvar g = 0; g < UNITS; g++) begin : g_check
      a_idle_lines_high : assert property (
         st_reg.unit[g] == ST_IDLE |-> o_unit_lines.unit_working_n[g]
            && o_unit_lines.unit_result_good_n[g] && o_unit_lines.unit_result_bad_n[g])
         else $error("idle unit drives a line low");
      a_start_busy_low : assert property (
         o_engine_start[g] |-> !o_unit_lines.unit_working_n[g]
            && o_unit_lines.unit_result_good_n[g] && o_unit_lines.unit_result_bad_n[g])
         else $error("start without busy low");
      a_done_result : assert property (
         st_reg.unit[g] == ST_WORK && i_engine.done[g] |=> o_unit_lines.unit_working_n[g]
            && o_unit_lines.unit_result_good_n[g] == !$past(i_engine.pass[g])
            && o_unit_lines.unit_result_bad_n[g] == $past(i_engine.pass[g]))
         else $error("completion result wrong");
      a_one_result_only : assert property (
         !(o_unit_lines.unit_result_good_n[g] == 1'b0
            && o_unit_lines.unit_result_bad_n[g] == 1'b0))
         else $error("pass and fail both low");
      a_result_needs_busy_high : assert property (
         !o_unit_lines.unit_working_n[g] |-> o_unit_lines.unit_result_good_n[g]
            && o_unit_lines.unit_result_bad_n[g])
         else $error("result low while busy low");
      a_single_own_line : assert property (
         o_engine_start[g] && !$past(st_reg.mode_sync) |->
            $past(width_ok[g]) && $past(st_reg.go_sync[g], 1)
            && !$past(st_reg.go_prev[g], 1))
         else $error("single mode start without own legal pulse");
      a_start_one_cycle : assert property (
         o_engine_start[g] |=> !o_engine_start[g])
         else $error("engine start longer than one cycle");
   end

   c_unit_pass : cover property (
      o_unit_lines.unit_working_n[0] && !o_unit_lines.unit_result_good_n[0]);
   c_unit_fail : cover property (
      o_unit_lines.unit_working_n[0] && !o_unit_lines.unit_result_bad_n[0]);
   c_busy_toggle : cover property (
      st_reg.unit[0] == ST_WORK && o_unit_lines.unit_working_n[0]);
   c_restart_after_done : cover property (
      st_reg.unit[1] == ST_DONE && start_ok[1]);
endmodule // gang_programmer_handshake
`default_nettype wire

// *** verif/handler_model.sv ***
// Handler side of the control bus: drives the start requests, reads the results.
// Assumes the bench calls its tasks; lines toward the device are active low.
`timescale 1ns/10ps
`default_nettype none
module handler_model #(
   parameter int unsigned CPM = 4
) (
   input  wire logic                             i_clock,
   input  wire gang_handshake_pkg::unit_lines_t  i_lines,
   output var  logic [3:0]                       o_go_n
);
   initial o_go_n = 4'hF;
   // Width given in ms, each ms being CPM clocks
   task automatic pulse(input int u, input int ms);
      @(negedge i_clock);
      o_go_n[u] = 1'b0;
      repeat (ms * CPM) @(negedge i_clock);
      o_go_n[u] = 1'b1;
   endtask
   // Busy high with both results high is not final, so keep waiting
   task automatic get_result(input int u, output logic [1:0] res);
      res = 2'b11;
      for (int i = 0; i < 200 && res === 2'b11; i++) begin
         @(negedge i_clock);
         if (i_lines.unit_working_n[u] === 1'b1)
            res = {i_lines.unit_result_good_n[u], i_lines.unit_result_bad_n[u]};
      end
   endtask
endmodule // handler_model
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the four-unit handler handshake.
// Assumes a shortened millisecond of 4 clocks; the bench plays the engines.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import gang_handshake_pkg::*;
   logic           i_clock = 1'b0;
   logic           i_reset_n = 1'b0;
   logic           all_n = 1'b1;
   logic           all_mode = 1'b0;
   logic [3:0]     go_n;
   logic [3:0]     start;
   engine_status_t eng = '0;
   unit_lines_t    lines;
   int             n_errors = 0;
   int             num_checks = 0;

   always #2.5 i_clock = ~i_clock;

   gang_programmer_handshake #(.CYCLES_PER_MS_P(4)) dut_u (
      .i_clock(i_clock), .i_reset_n(i_reset_n), .i_unit_go_request_n(go_n),
      .i_all_start_mode(all_mode), .i_all_start_n(all_n), .i_engine(eng),
      .o_unit_lines(lines), .o_engine_start(start));
   handler_model #(.CPM(4)) hm (.i_clock(i_clock), .i_lines(lines), .o_go_n(go_n));

   task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic results();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Counts start pulses of one unit over a fixed span
   task automatic count_starts(input int u, input int n, output int seen);
      seen = 0;
      repeat (n) begin
         @(negedge i_clock);
         if (start[u] === 1'b1) seen++;
      end
   endtask

   task automatic run_unit(input int u, input int ms, input logic pass, input logic pz);
      logic [1:0] r;
      int         seen;
      hm.pulse(u, ms);
      count_starts(u, 12, seen);
      chk("start pulses", 4'd1, 4'(seen));
      chk("busy low", 4'h0, {3'b0, lines.unit_working_n[u]});
      chk("pass cleared", 4'h1, {3'b0, lines.unit_result_good_n[u]});
      chk("fail cleared", 4'h1, {3'b0, lines.unit_result_bad_n[u]});
      if (pz) begin
         eng.pause[u] = 1'b1;
         repeat (3) @(negedge i_clock);
         chk("busy toggles", 4'h1, {3'b0, lines.unit_working_n[u]});
         chk("no pass yet", 4'h1, {3'b0, lines.unit_result_good_n[u]});
         chk("no fail yet", 4'h1, {3'b0, lines.unit_result_bad_n[u]});
         eng.pause[u] = 1'b0;
         repeat (3) @(negedge i_clock);
         chk("busy back low", 4'h0, {3'b0, lines.unit_working_n[u]});
      end
      eng.done[u] = 1'b1;
      eng.pass[u] = pass;
      @(negedge i_clock);
      eng.done[u] = 1'b0;
      hm.get_result(u, r);
      chk("result", {2'b0, ~pass, pass}, {2'b0, r});
   endtask

   task automatic refused(input int u, input int ms);
      int         seen;
      logic [2:0] l3;
      hm.pulse(u, ms);
      count_starts(u, 20, seen);
      chk("refused width", 4'd0, 4'(seen));
      l3 = {lines.unit_working_n[u], lines.unit_result_good_n[u], lines.unit_result_bad_n[u]};
      chk("lines idle", 4'h7, {1'b0, l3});
   endtask

   // Shared start button must not start anything in single-start mode
   task automatic shared_start_ignored();
      int seen;
      seen = 0;
      @(negedge i_clock);
      all_n = 1'b0;
      repeat (10) begin
         @(negedge i_clock);
         if (start !== 4'h0) seen++;
      end
      all_n = 1'b1;
      repeat (20) begin
         @(negedge i_clock);
         if (start !== 4'h0) seen++;
      end
      chk("shared pulses", 4'd0, 4'(seen));
      chk("shared start", 4'hF, lines.unit_working_n);
      chk("no start", 4'h0, start);
   endtask

   // In all-start mode the shared button starts every idle or finished unit together
   task automatic all_start_used();
      int seen;
      seen = 0;
      @(negedge i_clock);
      all_mode = 1'b1;
      repeat (4) @(negedge i_clock);
      all_n = 1'b0;
      repeat (10) begin
         @(negedge i_clock);
         if (start === 4'hF) seen++;
      end
      all_n = 1'b1;
      chk("all start pulses", 4'd1, 4'(seen));
      chk("all start busy", 4'h0, lines.unit_working_n);
      chk("all cleared", 4'hF, lines.unit_result_good_n & lines.unit_result_bad_n);
      eng.pass = 4'hF;
      eng.done = 4'hF;
      @(negedge i_clock);
      eng.done = 4'h0;
      @(negedge i_clock);
      chk("all pass low", 4'h0, lines.unit_result_good_n);
      chk("all fail high", 4'hF, lines.unit_result_bad_n);
      chk("all busy high", 4'hF, lines.unit_working_n);
      all_mode = 1'b0;
   endtask

   // A reset in mid-run drops every result at once and leaves the unit idle
   task automatic reset_again();
      @(negedge i_clock);
      i_reset_n = 1'b0;
      @(negedge i_clock);
      chk("mid reset busy", 4'hF, lines.unit_working_n);
      chk("mid reset", 4'hF, lines.unit_result_good_n & lines.unit_result_bad_n);
      repeat (2) @(negedge i_clock);
      i_reset_n = 1'b1;
      repeat (2) @(negedge i_clock);
      chk("after reset pass", 4'hF, lines.unit_result_good_n);
      chk("after reset start", 4'h0, start);
   endtask

   initial begin
      repeat (2) @(negedge i_clock);
      chk("reset busy", 4'hF, lines.unit_working_n);
      repeat (6) @(negedge i_clock);
      i_reset_n = 1'b1;
      @(negedge i_clock);
      chk("idle lines", 4'hF, lines.unit_result_good_n & lines.unit_result_bad_n);
      run_unit(0, 50, 1'b1, 1'b0);
      run_unit(1, 80, 1'b0, 1'b1);
      chk("unit0 held", 4'h0, {3'b0, lines.unit_result_good_n[0]});
      refused(2, 40);
      refused(2, 90);
      shared_start_ignored();
      run_unit(0, 60, 1'b0, 1'b0);
      all_start_used();
      reset_again();
      results();
   end

   initial begin
      #100_000;
      n_errors++;
      results();
   end
endmodule // tb_top
`default_nettype wire
